// ===== sms_starter_mode_sequencer.sv
// What this block does
// - Delta on timer, or early on low current
// - Transition energizes up-to-speed relay, run stays
// - Running holds until start removed or fault
// - Delta feedback enabled trips after feedback time
// - Star-delta ignores ramp, kick, decel settings
// - Star-delta holds thyristor gates inactive
// - Phase mode: run relay, firing from analog
// - Phase firing proportional, zero to full
// - Analog input scaled by offset and span
// - Analog output option ten shows firing level
// - Phase mode ignores ramp, kick, decel settings
// - Phase and follower offer listed protections only
// - Follower: run relay, gating, closed current loop
// - Follower full reference commands full load current
// - Follower mode ignores ramp, kick, decel settings
// - Full voltage: run relay, then up-to-speed relay
// - Full voltage keeps protections except stack ones
// - Full voltage ignores ramp, kick, decel settings
// - Full voltage holds thyristor gates inactive
// - Star-delta start energizes run relay first
// - Star-delta needs run and up-to-speed relays
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module sms_starter_mode_sequencer
    import sms_pkg::*;
#(
    parameter int MS_CYCLES = SMS_MS_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        start_cmd,
    input  wire logic        fault_in,
    input  wire logic        delta_contactor_fb,
    input  wire logic        line_zero_cross,
    input  wire logic [11:0] analog_in,
    input  wire logic [11:0] motor_current,
    output logic             run_relay,
    output logic             up_to_speed_relay,
    output logic             gate_enable,
    output logic      [12:0] firing_level,
    output logic      [12:0] analog_out,
    output logic      [12:0] prot_enable,
    output logic             trip
);

    typedef struct packed {
        sms_state_t  state;
        sms_mode_t   mode;
        logic        run_rly;
        logic        uts_rly;
        logic        gate_en;
        logic        trip_o;
        logic [12:0] firing;
        logic [12:0] aout;
        logic [12:0] prot;
        logic [15:0] tick_cnt;
        logic [15:0] ms;
        logic [15:0] fb_ms;
        logic        start_s1;
        logic        start_s2;
        logic        flt_s1;
        logic        flt_s2;
        logic        fb_s1;
        logic        fb_s2;
        logic        zc_s1;
        logic        zc_s2;
        logic        zc_d;
        sms_mode_t   cfg_mode;
        logic        fb_en;
        logic [3:0]  aout_func;
        logic [15:0] uts_time;
        logic [15:0] fb_time;
        logic [11:0] flc;
        logic [11:0] ain_off;
        logic [11:0] ain_span;
        logic        cause_flt;
        logic        cause_fb;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } sms_regs_t;

    localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

    sms_regs_t r_ff;
    sms_regs_t nxt_r;

    logic        ms_tick;
    logic        half_cycle;
    logic [12:0] diff;
    logic [23:0] prod;
    logic [12:0] ref_scaled;
    logic [24:0] tgt_prod;
    logic [12:0] cur_tgt;
    logic [19:0] cur_lhs;
    logic [18:0] cur_rhs;
    logic [22:0] time_lhs;
    logic [22:0] time_rhs;
    logic        early_ok;
    logic        uts_done;
    logic        wr_acc;
    logic        clr_req;
    logic [31:0] rd_data;
    logic        rd_hit;

    always_comb begin
        ms_tick    = (r_ff.tick_cnt == MS_LAST);
        half_cycle = r_ff.zc_s2 & ~r_ff.zc_d;
        // Negative offset results clamp to zero, large ones to full scale.
        diff = {1'b0, analog_in} - {1'b0, r_ff.ain_off};
        prod = (diff[12] ? 24'h000000 : {12'h000, diff[11:0]})
               * {12'h000, r_ff.ain_span};
        if ((prod >> SMS_SPAN_SHIFT) > {11'h000, SMS_REF_FULL}) begin
            ref_scaled = SMS_REF_FULL;
        end else begin
            ref_scaled = prod[SMS_SPAN_SHIFT +: 13];
        end
        // Full reference gives exactly the full load current.
        tgt_prod = {12'h000, ref_scaled} * {13'h0000, r_ff.flc};
        cur_tgt  = tgt_prod[SMS_REF_SHIFT +: 13];
        cur_lhs  = {8'h00, motor_current} * {13'h0000, SMS_HUNDRED};
        cur_rhs  = 19'({7'h00, r_ff.flc} * {12'h000, SMS_CUR_PCT});
        time_lhs = {7'h00, r_ff.ms} * {16'h0000, SMS_HUNDRED};
        time_rhs = {7'h00, r_ff.uts_time} * {16'h0000, SMS_TIME_PCT};
        early_ok = (cur_lhs < {1'b0, cur_rhs})
                   && (time_lhs >= time_rhs);
        uts_done = (r_ff.ms >= r_ff.uts_time);
        wr_acc   = psel & penable & pwrite & r_ff.pready;
        clr_req  = wr_acc && (paddr == SMS_CTRL_OFS)
                   && pwdata[SMS_CTRL_CLR_BIT];
    end

    always_comb begin
        rd_hit  = 1'b1;
        rd_data = 32'h00000000;
        case (paddr)
            SMS_CTRL_OFS: begin
                rd_data[SMS_CTRL_MODE_LSB +: 2] = r_ff.cfg_mode;
                rd_data[SMS_CTRL_FBEN_BIT]      = r_ff.fb_en;
                rd_data[SMS_CTRL_AOF_LSB +: 4]  = r_ff.aout_func;
            end
            SMS_UTST_OFS:  rd_data[15:0] = r_ff.uts_time;
            SMS_FBT_OFS:   rd_data[15:0] = r_ff.fb_time;
            SMS_FLC_OFS:   rd_data[11:0] = r_ff.flc;
            SMS_AOFS_OFS:  rd_data[11:0] = r_ff.ain_off;
            SMS_ASPAN_OFS: rd_data[11:0] = r_ff.ain_span;
            SMS_STAT_OFS: begin
                rd_data[2:0] = r_ff.state;
                rd_data[4:3] = r_ff.mode;
                rd_data[5]   = r_ff.run_rly;
                rd_data[6]   = r_ff.uts_rly;
                rd_data[7]   = r_ff.gate_en;
                rd_data[8]   = r_ff.trip_o;
                rd_data[9]   = r_ff.cause_flt;
                rd_data[10]  = r_ff.cause_fb;
            end
            SMS_FIRE_OFS: begin
                rd_data[12:0]  = r_ff.firing;
                rd_data[28:16] = ref_scaled;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        nxt_r = r_ff;

        nxt_r.start_s1 = start_cmd;
        nxt_r.start_s2 = r_ff.start_s1;
        nxt_r.flt_s1   = fault_in;
        nxt_r.flt_s2   = r_ff.flt_s1;
        nxt_r.fb_s1    = delta_contactor_fb;
        nxt_r.fb_s2    = r_ff.fb_s1;
        nxt_r.zc_s1    = line_zero_cross;
        nxt_r.zc_s2    = r_ff.zc_s1;
        nxt_r.zc_d     = r_ff.zc_s2;

        nxt_r.tick_cnt = ms_tick ? 16'h0000 : r_ff.tick_cnt + 16'h0001;

        // APB slave: one access cycle, error on unmapped addresses.
        nxt_r.pready  = psel & ~penable & ~r_ff.pready;
        nxt_r.pslverr = psel & ~penable & ~r_ff.pready & ~rd_hit;
        if (psel & ~penable & ~r_ff.pready & ~pwrite) begin
            nxt_r.prdata = rd_data;
        end
        if (wr_acc) begin
            case (paddr)
                SMS_CTRL_OFS: begin
                    nxt_r.cfg_mode  =
                        sms_mode_t'(pwdata[SMS_CTRL_MODE_LSB +: 2]);
                    nxt_r.fb_en     = pwdata[SMS_CTRL_FBEN_BIT];
                    nxt_r.aout_func = pwdata[SMS_CTRL_AOF_LSB +: 4];
                end
                SMS_UTST_OFS:  nxt_r.uts_time = pwdata[15:0];
                SMS_FBT_OFS:   nxt_r.fb_time  = pwdata[15:0];
                SMS_FLC_OFS:   nxt_r.flc      = pwdata[11:0];
                SMS_AOFS_OFS:  nxt_r.ain_off  = pwdata[11:0];
                SMS_ASPAN_OFS: nxt_r.ain_span = pwdata[11:0];
                default: ;
            endcase
        end

        if (ms_tick && r_ff.ms != 16'hffff) begin
            nxt_r.ms = r_ff.ms + 16'h0001;
        end
        if (ms_tick && r_ff.fb_ms != 16'hffff) begin
            nxt_r.fb_ms = r_ff.fb_ms + 16'h0001;
        end

        // Trip causes are sticky; a new cause beats a clear.
        if (clr_req && r_ff.state != SMS_ST_FAULT) begin
            nxt_r.cause_flt = 1'b0;
            nxt_r.cause_fb  = 1'b0;
        end

        case (r_ff.state)
            SMS_ST_IDLE: begin
                nxt_r.mode   = r_ff.cfg_mode;
                nxt_r.ms     = 16'h0000;
                nxt_r.firing = 13'h0000;
                if (r_ff.flt_s2) begin
                    nxt_r.cause_flt = 1'b1;
                    nxt_r.state     = SMS_ST_FAULT;
                end else if (r_ff.start_s2) begin
                    nxt_r.state = SMS_ST_START;
                end
            end
            SMS_ST_START: begin
                if (r_ff.flt_s2) begin
                    nxt_r.cause_flt = 1'b1;
                    nxt_r.state     = SMS_ST_FAULT;
                end else if (!r_ff.start_s2) begin
                    nxt_r.state = SMS_ST_IDLE;
                end else begin
                    case (r_ff.mode)
                        SMS_MODE_STARDELTA: begin
                            if (uts_done || early_ok) begin
                                nxt_r.fb_ms = 16'h0000;
                                nxt_r.state = SMS_ST_XFER;
                            end
                        end
                        SMS_MODE_FULLV: begin
                            if (uts_done) begin
                                nxt_r.state = SMS_ST_RUN;
                            end
                        end
                        default: nxt_r.state = SMS_ST_RUN;
                    endcase
                end
            end
            SMS_ST_XFER: begin
                if (r_ff.flt_s2) begin
                    nxt_r.cause_flt = 1'b1;
                    nxt_r.state     = SMS_ST_FAULT;
                end else if (!r_ff.start_s2) begin
                    nxt_r.state = SMS_ST_IDLE;
                end else if (!r_ff.fb_en || r_ff.fb_s2) begin
                    nxt_r.state = SMS_ST_RUN;
                end else if (r_ff.fb_ms >= r_ff.fb_time) begin
                    nxt_r.cause_fb = 1'b1;
                    nxt_r.state    = SMS_ST_FAULT;
                end
            end
            SMS_ST_RUN: begin
                if (r_ff.flt_s2) begin
                    nxt_r.cause_flt = 1'b1;
                    nxt_r.state     = SMS_ST_FAULT;
                end else if (!r_ff.start_s2) begin
                    nxt_r.state = SMS_ST_IDLE;
                end
            end
            SMS_ST_FAULT: begin
                nxt_r.firing = 13'h0000;
                if (r_ff.flt_s2) begin
                    nxt_r.cause_flt = 1'b1;
                end
                if (clr_req && !r_ff.flt_s2 && !r_ff.start_s2) begin
                    nxt_r.state = SMS_ST_IDLE;
                end
            end
            default: nxt_r.state = SMS_ST_IDLE;
        endcase

        // Firing comes from the reference or the follower current loop; no ramp or kick shaping.
        if (r_ff.state == SMS_ST_START || r_ff.state == SMS_ST_RUN) begin
            if (half_cycle && r_ff.mode == SMS_MODE_PHASE) begin
                nxt_r.firing = ref_scaled;
            end else if (half_cycle && r_ff.mode == SMS_MODE_FOLLOW) begin
                // Integrating loop steps the firing toward the target.
                if ({1'b0, motor_current} < cur_tgt) begin
                    if (r_ff.firing > SMS_REF_FULL - SMS_LOOP_STEP) begin
                        nxt_r.firing = SMS_REF_FULL;
                    end else begin
                        nxt_r.firing = r_ff.firing + SMS_LOOP_STEP;
                    end
                end else if ({1'b0, motor_current} > cur_tgt) begin
                    if (r_ff.firing < SMS_LOOP_STEP) begin
                        nxt_r.firing = 13'h0000;
                    end else begin
                        nxt_r.firing = r_ff.firing - SMS_LOOP_STEP;
                    end
                end
            end else if (r_ff.mode == SMS_MODE_STARDELTA
                         || r_ff.mode == SMS_MODE_FULLV) begin
                nxt_r.firing = 13'h0000;
            end
        end
        if (nxt_r.state == SMS_ST_FAULT) begin
            nxt_r.firing = 13'h0000;
        end

        // Relays and gating follow the next state so they are registered.
        nxt_r.run_rly = (nxt_r.state == SMS_ST_START)
                        || (nxt_r.state == SMS_ST_XFER)
                        || (nxt_r.state == SMS_ST_RUN);
        nxt_r.uts_rly = (nxt_r.state == SMS_ST_XFER)
                        || (nxt_r.state == SMS_ST_RUN
                            && (r_ff.mode == SMS_MODE_STARDELTA
                                || r_ff.mode == SMS_MODE_FULLV));
        nxt_r.gate_en = nxt_r.run_rly
                        && (r_ff.mode == SMS_MODE_PHASE
                            || r_ff.mode == SMS_MODE_FOLLOW);
        nxt_r.trip_o  = (nxt_r.state == SMS_ST_FAULT);

        case (r_ff.mode)
            SMS_MODE_PHASE,
            SMS_MODE_FOLLOW: nxt_r.prot = SMS_PROT_LISTED;
            SMS_MODE_STARDELTA,
            SMS_MODE_FULLV:  nxt_r.prot = SMS_PROT_NOSTACK;
            default:         nxt_r.prot = SMS_PROT_NONE;
        endcase

        if (r_ff.aout_func == SMS_AOUT_FIRING) begin
            nxt_r.aout = r_ff.firing;
        end else begin
            nxt_r.aout = 13'h0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_ff          <= '0;
            r_ff.state    <= SMS_ST_IDLE;
            r_ff.mode     <= SMS_MODE_STARDELTA;
            r_ff.cfg_mode <= SMS_MODE_STARDELTA;
            r_ff.uts_time <= SMS_UTST_RST;
            r_ff.fb_time  <= SMS_FBT_RST;
            r_ff.flc      <= SMS_FLC_RST;
            r_ff.ain_off  <= SMS_AOFS_RST;
            r_ff.ain_span <= SMS_ASPAN_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign prdata            = r_ff.prdata;
    assign pready            = r_ff.pready;
    assign pslverr           = r_ff.pslverr;
    assign run_relay         = r_ff.run_rly;
    assign up_to_speed_relay = r_ff.uts_rly;
    assign gate_enable       = r_ff.gate_en;
    assign firing_level      = r_ff.firing;
    assign analog_out        = r_ff.aout;
    assign prot_enable       = r_ff.prot;
    assign trip              = r_ff.trip_o;

endmodule
`default_nettype wire

// ===== sms_pkg.sv
package sms_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] SMS_CTRL_OFS   = 8'h00;
    localparam logic [7:0] SMS_UTST_OFS   = 8'h04;
    localparam logic [7:0] SMS_FBT_OFS    = 8'h08;
    localparam logic [7:0] SMS_FLC_OFS    = 8'h0c;
    localparam logic [7:0] SMS_AOFS_OFS   = 8'h10;
    localparam logic [7:0] SMS_ASPAN_OFS  = 8'h14;
    localparam logic [7:0] SMS_STAT_OFS   = 8'h18;
    localparam logic [7:0] SMS_FIRE_OFS   = 8'h1c;

    // CTRL field positions.
    localparam int SMS_CTRL_MODE_LSB = 0;
    localparam int SMS_CTRL_FBEN_BIT = 2;
    localparam int SMS_CTRL_AOF_LSB  = 4;
    localparam int SMS_CTRL_CLR_BIT  = 8;

    // Reset values.
    localparam logic [15:0] SMS_UTST_RST  = 16'h2710;
    localparam logic [15:0] SMS_FBT_RST   = 16'h01f4;
    localparam logic [11:0] SMS_FLC_RST   = 12'h800;
    localparam logic [11:0] SMS_AOFS_RST  = 12'h000;
    localparam logic [11:0] SMS_ASPAN_RST = 12'h400;

    // Reference scale: 4096 is 100 percent; span 1024 is unity gain.
    localparam logic [12:0] SMS_REF_FULL   = 13'h1000;
    localparam int          SMS_SPAN_SHIFT = 10;
    localparam int          SMS_REF_SHIFT  = 12;
    localparam logic [12:0] SMS_LOOP_STEP  = 13'h0010;

    // Early transition thresholds in percent.
    localparam logic [6:0] SMS_CUR_PCT  = 7'h55;
    localparam logic [6:0] SMS_TIME_PCT = 7'h19;
    localparam logic [6:0] SMS_HUNDRED  = 7'h64;

    localparam logic [3:0] SMS_AOUT_FIRING = 4'ha;

    // Timing: a millisecond tick derived from the 40 ns clock.
    localparam int SMS_CLK_NS = 40;
    localparam int SMS_MS_NS  = 1000000;
    localparam int SMS_MS_CYC = SMS_MS_NS / SMS_CLK_NS;

    typedef enum logic [1:0] {
        SMS_MODE_STARDELTA = 2'h0,
        SMS_MODE_PHASE     = 2'h1,
        SMS_MODE_FOLLOW    = 2'h2,
        SMS_MODE_FULLV     = 2'h3
    } sms_mode_t;

    typedef enum logic [2:0] {
        SMS_ST_IDLE  = 3'h0,
        SMS_ST_START = 3'h1,
        SMS_ST_XFER  = 3'h3,
        SMS_ST_RUN   = 3'h2,
        SMS_ST_FAULT = 3'h6
    } sms_state_t;

    // Protection enable width and masks.
    localparam int SMS_PROT_W = 13;
    localparam logic [12:0] SMS_PROT_LISTED  = 13'h07ff;
    localparam logic [12:0] SMS_PROT_NOSTACK = 13'h07ff;
    localparam logic [12:0] SMS_PROT_NONE    = 13'h0000;

endpackage

// ===== sms_seq_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module sms_seq_asserts
    import sms_pkg::*;
#(
    parameter int MS_CYCLES = SMS_MS_CYC
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        start_cmd,
    input wire logic        run_relay,
    input wire logic        up_to_speed_relay,
    input wire logic        gate_enable,
    input wire logic [12:0] firing_level,
    input wire logic [12:0] analog_out,
    input wire logic [12:0] prot_enable,
    input wire logic        trip
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stopped;
        !start_cmd [*5];
    endsequence
    sequence s_outputs_off;
        !run_relay && !up_to_speed_relay && !gate_enable;
    endsequence

    property p_apb_answer;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    property p_stop;
        s_stopped |-> s_outputs_off;
    endproperty
    property p_uts_run;
        up_to_speed_relay |-> run_relay;
    endproperty
    property p_gate_no_uts;
        gate_enable |-> !up_to_speed_relay;
    endproperty
    property p_gate_run;
        gate_enable |-> run_relay;
    endproperty
    property p_trip_off;
        trip |-> s_outputs_off and firing_level == 13'h0000;
    endproperty
    property p_fire_max;
        firing_level <= SMS_REF_FULL;
    endproperty
    property p_aout;
        analog_out != 13'h0000 |-> analog_out == $past(firing_level);
    endproperty
    property p_prot;
        $past(presetn) |-> prot_enable == SMS_PROT_LISTED;
    endproperty
    property p_run_start;
        $rose(run_relay) |-> $past(start_cmd, 2);
    endproperty
    property p_wye_first;
        $rose(up_to_speed_relay) |-> $past(run_relay);
    endproperty

    a_apb_answer: assert property (p_apb_answer)
        else $error("apb answer not a single cycle");
    a_stop: assert property (p_stop)
        else $error("outputs stay on after start removed");
    a_uts_run: assert property (p_uts_run)
        else $error("up to speed relay without run relay");
    a_gate_no_uts: assert property (p_gate_no_uts)
        else $error("gates on with up to speed relay");
    a_gate_run: assert property (p_gate_run)
        else $error("gates on without run relay");
    a_trip_off: assert property (p_trip_off)
        else $error("outputs on while tripped");
    a_fire_max: assert property (p_fire_max)
        else $error("firing level above full");
    a_aout: assert property (p_aout)
        else $error("analog out does not follow firing");
    a_prot: assert property (p_prot)
        else $error("protection enables wrong");
    a_run_start: assert property (p_run_start)
        else $error("run relay without start");
    a_wye_first: assert property (p_wye_first)
        else $error("up to speed relay before run relay");
endmodule
bind sms_starter_mode_sequencer sms_seq_asserts #(.MS_CYCLES(MS_CYCLES))
    u_sms_seq_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .start_cmd(start_cmd),
    .run_relay(run_relay), .up_to_speed_relay(up_to_speed_relay),
    .gate_enable(gate_enable), .firing_level(firing_level),
    .analog_out(analog_out), .prot_enable(prot_enable), .trip(trip));
`default_nettype wire

// ===== sms_far_side_model.sv
`timescale 1ns/1ns
`default_nettype none
module sms_far_side_model #(
    parameter int ZC_PERIOD = 40
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        up_to_speed_relay,
    input  wire logic [15:0] fb_delay,
    output var  logic        delta_contactor_fb,
    output var  logic        line_zero_cross
);
    int fb_cnt;
    int zc_cnt;
    // A delay of zero models a delta contactor that never closes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fb_cnt <= 0;
            zc_cnt <= 0;
            delta_contactor_fb <= 1'b0;
            line_zero_cross <= 1'b0;
        end else begin
            zc_cnt <= (zc_cnt == ZC_PERIOD - 1) ? 0 : zc_cnt + 1;
            line_zero_cross <= (zc_cnt < ZC_PERIOD / 2);
            if (!up_to_speed_relay) begin
                fb_cnt <= 0;
                delta_contactor_fb <= 1'b0;
            end else begin
                fb_cnt <= fb_cnt + 1;
                delta_contactor_fb <= (fb_delay != 16'h0000) &&
                    (fb_cnt >= int'(fb_delay));
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb_starter_mode_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
    $display("Error %s expected %0h seen %0h", nm, e, s); n_errors++; end end
module tb_starter_mode_sequencer import sms_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        start_cmd, fault_in, delta_contactor_fb, line_zero_cross;
    logic        run_relay, up_to_speed_relay, gate_enable, trip;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] analog_in, motor_current, raw, off, sp;
    logic [12:0] firing_level, analog_out, prot_enable, ex;
    logic [15:0] fb_delay;
    logic [3:0]  hits;
    logic [31:0] rst_tab [6] = '{32'h0, {16'h0, SMS_UTST_RST},
        {16'h0, SMS_FBT_RST}, {20'h0, SMS_FLC_RST}, {20'h0, SMS_AOFS_RST},
        {20'h0, SMS_ASPAN_RST}};
    int          n_errors, checks_done, cyc, i, t;

    sms_starter_mode_sequencer #(.MS_CYCLES(10)) u_sms_starter_mode_sequencer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .start_cmd(start_cmd),
        .fault_in(fault_in), .delta_contactor_fb(delta_contactor_fb),
        .line_zero_cross(line_zero_cross), .analog_in(analog_in),
        .motor_current(motor_current), .run_relay(run_relay),
        .up_to_speed_relay(up_to_speed_relay), .gate_enable(gate_enable),
        .firing_level(firing_level), .analog_out(analog_out),
        .prot_enable(prot_enable), .trip(trip));
    sms_far_side_model u_sms_far_side_model (.pclk(pclk), .presetn(presetn),
        .up_to_speed_relay(up_to_speed_relay), .fb_delay(fb_delay),
        .delta_contactor_fb(delta_contactor_fb),
        .line_zero_cross(line_zero_cross));

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_errors == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    function automatic logic [12:0] exp_ref(input logic [11:0] r, o, s);
        logic [24:0] p;
        p = (r > o) ? 25'(r - o) * 25'(s) : 25'h0;
        p = p >> SMS_SPAN_SHIFT;
        return (p > 25'h1000) ? SMS_REF_FULL : p[12:0];
    endfunction
    function automatic int trans_ms(input int ut, input int cur);
        return (cur * 100 < SMS_FLC_RST * 85) ? (ut * 25 + 99) / 100 : ut;
    endfunction
    assign hits = {run_relay === 1'b0, trip === 1'b1,
                   up_to_speed_relay === 1'b1, run_relay === 1'b1};
    task automatic track(input int n);
        repeat (n) begin
            @(posedge pclk);
            motor_current <= firing_level[11:0];
        end
    endtask
    task automatic wt(input int k, input int lim);
        t = 0;
        while (t < lim && !hits[k]) begin
            @(posedge pclk);
            t++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic stop_and_clear();
        start_cmd <= 1'b0;
        fault_in <= 1'b0;
        wt(3, 10);
        repeat (5) @(posedge pclk);
        repeat (2) apb(1'b1, SMS_CTRL_OFS, 32'h100);
        @(posedge pclk);
        `CHK("trip cleared", 1'b0, trip)
    endtask
    task automatic sd(input int ut, input logic [11:0] cur, input logic fben,
                      input logic [15:0] dly);
        int e;
        apb(1'b1, SMS_UTST_OFS, 32'(ut));
        apb(1'b1, SMS_FBT_OFS, 32'h5);
        apb(1'b1, SMS_CTRL_OFS, {29'h0, fben, 2'h0});
        fb_delay <= dly;
        motor_current <= cur;
        start_cmd <= 1'b1;
        wt(0, 10);
        wt(1, ut * 12 + 20);
        e = trans_ms(ut, int'(cur));
        `CHK("transition time", 1'b1, t >= (e-1)*10 && t <= e*10+3)
        `CHK("run with uts", 1'b1, run_relay)
        `CHK("gates off", 1'b0, gate_enable)
        repeat (60) @(posedge pclk);
        apb(1'b0, SMS_STAT_OFS, 32'h0);
        ex = (fben && dly == 16'h0) ? 13'h0406 : 13'h0002;
        `CHK("status after delta", {19'h0, ex}, rd & 32'h407)
        stop_and_clear();
    endtask

    initial begin
        {presetn, psel, penable, pwrite, start_cmd, fault_in} = 6'h0;
        {paddr, pwdata, analog_in, motor_current, fb_delay} = '0;
        n_errors = 0;
        checks_done = 0;
        cyc = 0;
        void'($urandom(6760));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            `CHK("reset value", rst_tab[i], rd)
        end
        apb(1'b1, 8'h20, 32'hffff);
        `CHK("unmapped error", 1'b1, err)
        apb(1'b1, SMS_STAT_OFS, 32'hffff);
        apb(1'b0, SMS_STAT_OFS, 32'h0);
        `CHK("status read only", 32'h0, rd & 32'h7ff)
        sd(4, 12'hfff, 1'b0, 16'h0);
        sd(20, 12'h100, 1'b1, 16'd20);
        sd(8, 12'h100, 1'b1, 16'h0);
        for (i = 0; i < 3; i++) begin
            sd(4 + $urandom % 16, 12'($urandom), 1'b1, 16'd20);
        end
        apb(1'b1, SMS_CTRL_OFS, 32'ha1);
        start_cmd <= 1'b1;
        wt(0, 10);
        `CHK("phase gating", 1'b1, gate_enable)
        for (i = 0; i < 6; i++) begin
            raw = (i == 0) ? 12'h0 : (i == 5) ? 12'hfff : 12'($urandom);
            off = (i % 5 == 0) ? 12'h0 : 12'($urandom % 1024);
            sp = (i == 5) ? 12'h800 : 12'($urandom);
            apb(1'b1, SMS_AOFS_OFS, {20'h0, off});
            apb(1'b1, SMS_ASPAN_OFS, {20'h0, sp});
            analog_in <= raw;
            repeat (100) @(posedge pclk);
            `CHK("firing", exp_ref(raw, off, sp), firing_level)
            `CHK("analog out", exp_ref(raw, off, sp), analog_out)
        end
        apb(1'b1, SMS_CTRL_OFS, 32'h3);
        apb(1'b0, SMS_STAT_OFS, 32'h0);
        `CHK("mode held", 2'h1, rd[4:3])
        `CHK("analog out off", 13'h0, analog_out)
        stop_and_clear();
        apb(1'b1, SMS_CTRL_OFS, 32'h2);
        apb(1'b1, SMS_FLC_OFS, 32'h100);
        analog_in <= 12'hfff;
        start_cmd <= 1'b1;
        track(1600);
        `CHK("follower full", 13'h100, firing_level)
        `CHK("follower gating", 1'b1, gate_enable)
        analog_in <= 12'h0;
        track(800);
        `CHK("follower zero", 13'h0, firing_level)
        stop_and_clear();
        apb(1'b1, SMS_CTRL_OFS, 32'h3);
        apb(1'b1, SMS_UTST_OFS, 32'h2);
        start_cmd <= 1'b1;
        wt(0, 10);
        wt(1, 60);
        `CHK("full voltage uts", 1'b1, t >= 10 && t <= 23)
        `CHK("full voltage gates", 1'b0, gate_enable)
        fault_in <= 1'b1;
        wt(2, 10);
        apb(1'b0, SMS_STAT_OFS, 32'h0);
        `CHK("fault status", 32'h206, rd & 32'h207)
        stop_and_clear();
        print_verdict();
    end
endmodule
`default_nettype wire
